/* gtm_defines.vh */
// Constants shared by the general timer block: map, fields, resets, timing
`ifndef GTM_DEFINES_VH
`define GTM_DEFINES_VH

// ****************************************************************
// Timer variant indices (address bits 3:2)
// ****************************************************************
`define GTM_IDX_A 2'h0
`define GTM_IDX_B 2'h1
`define GTM_IDX_C 2'h2

// ****************************************************************
// Register select within a timer (address bits 1:0)
// ****************************************************************
`define GTM_REG_CNT 2'h0
`define GTM_REG_PER 2'h1
`define GTM_REG_CTL 2'h2
`define GTM_REG_IRQ 2'h3

// ****************************************************************
// Control word field positions
// ****************************************************************
`define GTM_BIT_ON 15
`define GTM_BIT_SIDL 13
`define GTM_BIT_GATE 6
`define GTM_BIT_PS_HI 5
`define GTM_BIT_PS_LO 4
`define GTM_BIT_PAIR 3
`define GTM_BIT_SYNC 2
`define GTM_BIT_SRC 1

// Writable bits per variant; all others read as zero
`define GTM_WMASK_A 16'hA076
`define GTM_WMASK_B 16'hA07A
`define GTM_WMASK_C 16'hA072

// ****************************************************************
// Interrupt control word field positions
// ****************************************************************
`define GTM_BIT_IE 0
`define GTM_BIT_IF 1
`define GTM_BIT_IP_HI 4
`define GTM_BIT_IP_LO 2

// ****************************************************************
// Reset values
// ****************************************************************
`define GTM_RST_CNT 16'h0000
`define GTM_RST_PER 16'hFFFF
`define GTM_RST_CTL 16'h0000
`define GTM_RST_IP 3'h0
`define GTM_CNT_MAX 16'hFFFF

// ****************************************************************
// Timing: instruction clock is the system clock divided by four
// ****************************************************************
`define GTM_TCY_LAST 2'h3

// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define GTM_PS1_LAST 8'h00
`define GTM_PS8_LAST 8'h07
`define GTM_PS64_LAST 8'h3F
`define GTM_PS256_LAST 8'hFF

`endif

/* gtm_sync.v */
// Optional two-stage synchroniser with edge detection for one input level
`timescale 1ns/1ps
`include "gtm_defines.vh"
module gtm_sync (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Level in, bypass the synchroniser when high
  input wire d_i,
  input wire bypass_i,
  // Selected level and its edges
  output wire lvl_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // ****************************************************************
  // Synchroniser and edge history
  // ****************************************************************
  // First stage feeds only the second stage
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
      prev_q <= lvl_o;
    end
  end

  // Bypass trades two cycles of latency for no sampling at all
  assign lvl_o = bypass_i ? d_i : sync_q;
  assign rise_o = lvl_o & ~prev_q;
  assign fall_o = ~lvl_o & prev_q;

endmodule

/* gtm_prescale.v */
// Input prescaler: passes one of every 1, 8, 64 or 256 input ticks
`timescale 1ns/1ps
`include "gtm_defines.vh"
module gtm_prescale #(
  parameter W = 8
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Tick in, ratio select, synchronous clear
  input wire tick_i,
  input wire [1:0] sel_i,
  input wire clr_i,
  // Prescaled tick out
  output wire pulse_o
);

  reg [W-1:0] cnt_q;
  reg [W-1:0] last;

  // Terminal count for the selected ratio
  always @* begin
    case (sel_i)
      2'h0: last = `GTM_PS1_LAST;
      2'h1: last = `GTM_PS8_LAST;
      2'h2: last = `GTM_PS64_LAST;
      default: last = `GTM_PS256_LAST;
    endcase
  end

  assign pulse_o = tick_i & (cnt_q == last);

  // Divider counter; cleared while the timer is off so a restart is clean
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= {W{1'b0}};
    end else if (clr_i) begin
      cnt_q <= {W{1'b0}};
    end else if (tick_i) begin
      if (pulse_o) begin
        cnt_q <= {W{1'b0}};
      end else begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* gtm_timer.v */
// Three 16-bit timers of variants A, B and C with register port
`timescale 1ns/1ps
`include "gtm_defines.vh"
module gtm_timer #(
  parameter CW = 16,
  parameter PSW = 8
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [15:0] rdata_o,
  // External clock or gate pins, low-power oscillator
  input wire ext_clk_a_i,
  input wire ext_clk_b_i,
  input wire ext_clk_c_i,
  input wire lposc_clk_i,
  input wire lposc_en_i,
  // Device power state
  input wire idle_i,
  input wire sleep_i,
  // Interrupt request, priority and ADC trigger
  output wire [2:0] irq_req_o,
  output wire [8:0] irq_prio_o,
  output wire adc_trig_o
);

  // ****************************************************************
  // Shared state
  // ****************************************************************
  wire [3*CW-1:0] cnt_w;
  wire [3*CW-1:0] per_w;
  wire [3*CW-1:0] ctl_w;
  wire [3*CW-1:0] rb_w;
  wire [2:0] inc_w;
  wire [2:0] gfall_w;
  wire [2:0] hit_w;
  wire [2:0] set_w;
  wire [2:0] flag_w;
  wire [2:0] ien_w;
  wire [CW-1:0] cnt_a = cnt_w[CW-1:0];
  wire [CW-1:0] cnt_b = cnt_w[2*CW-1:CW];
  wire [CW-1:0] cnt_c = cnt_w[3*CW-1:2*CW];
  wire [CW-1:0] per_a = per_w[CW-1:0];
  wire [CW-1:0] per_b = per_w[2*CW-1:CW];
  wire [CW-1:0] per_c = per_w[3*CW-1:2*CW];
  wire pair_w = ctl_w[CW + `GTM_BIT_PAIR];
  reg [1:0] tcy_cnt_q;
  reg tcy_q;
  reg [15:0] rdata_q;
  reg [2:0] irq_q;
  reg adc_q;

  // ****************************************************************
  // Instruction clock enable
  // ****************************************************************
  // One pulse every four system clocks stands in for Fosc/4
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tcy_cnt_q <= 2'h0;
      tcy_q <= 1'b0;
    end else begin
      tcy_cnt_q <= tcy_cnt_q + 2'h1;
      tcy_q <= (tcy_cnt_q == `GTM_TCY_LAST);
    end
  end

  // ****************************************************************
  // Period match and flag events
  // ****************************************************************
  // Paired, the 32-bit compare lives on C and is clocked by B
  assign hit_w[0] = inc_w[0] & (cnt_a == per_a);
  assign hit_w[1] = inc_w[1] & ~pair_w & (cnt_b == per_b);
  assign hit_w[2] = pair_w ?
    (inc_w[1] & ({cnt_c, cnt_b} == {per_c, per_b})) :
    (inc_w[2] & (cnt_c == per_c));

  // Gate fall of B reports on C while paired
  assign set_w[0] = hit_w[0] | gfall_w[0];
  assign set_w[1] = hit_w[1] | (gfall_w[1] & ~pair_w);
  assign set_w[2] = hit_w[2] | (pair_w ? gfall_w[1] : gfall_w[2]);

  // ****************************************************************
  // Per-timer logic
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_tmr
      localparam [31:0] GI = gi;
      localparam [1:0] IDX = GI[1:0];
      localparam [15:0] WMASK = (IDX == `GTM_IDX_A) ? `GTM_WMASK_A :
        (IDX == `GTM_IDX_B) ? `GTM_WMASK_B : `GTM_WMASK_C;
      reg [CW-1:0] cnt_q;
      reg [CW-1:0] per_q;
      reg [15:0] ctl_q;
      reg ie_q;
      reg if_q;
      reg [2:0] ip_q;
      reg [15:0] rb;
      wire sel = (addr_i[3:2] == IDX);
      wire wr_cnt = wr_i & sel & (addr_i[1:0] == `GTM_REG_CNT);
      wire wr_per = wr_i & sel & (addr_i[1:0] == `GTM_REG_PER);
      wire wr_ctl = wr_i & sel & (addr_i[1:0] == `GTM_REG_CTL);
      wire wr_irq = wr_i & sel & (addr_i[1:0] == `GTM_REG_IRQ);
      wire on = ctl_q[`GTM_BIT_ON];
      wire ext_sel = ctl_q[`GTM_BIT_SRC];
      wire syn = ctl_q[`GTM_BIT_SYNC];
      wire gate = ctl_q[`GTM_BIT_GATE] & ~ext_sel;
      wire is_a = (IDX == `GTM_IDX_A);
      wire is_b = (IDX == `GTM_IDX_B);
      wire pin = is_a ? (lposc_en_i ? lposc_clk_i : ext_clk_a_i) :
        (is_b ? ext_clk_b_i : ext_clk_c_i);
      // Internal source ignores the sync bit, so a gate pin is sampled on A and C; B always bypasses
      wire byp = is_a ? (ext_sel & ~syn) : is_b;
      wire async_ok = is_a & ext_sel & ~syn;
      wire run = on & ~(idle_i & ctl_q[`GTM_BIT_SIDL]) &
        (~sleep_i | async_ok);
      wire pin_lvl;
      wire pin_rise;
      wire pin_fall;
      wire ps_pulse;
      wire adv;
      wire clr;
      // Source: gated internal, pin rising edge, or instruction clock
      wire src = gate ? (tcy_q & pin_lvl) :
        (ext_sel ? pin_rise : tcy_q);

      gtm_sync u_pin (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i(pin),
        .bypass_i(byp),
        .lvl_o(pin_lvl),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
      );

      gtm_prescale #(
        .W(PSW)
      ) u_ps (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .tick_i(src & run),
        .sel_i(ctl_q[`GTM_BIT_PS_HI:`GTM_BIT_PS_LO]),
        .clr_i(~on),
        .pulse_o(ps_pulse)
      );

      if (gi == 1) begin : g_post
        // Prescaled pin ticks cross as a toggle, after the divider
        reg tog_q;
        wire t_rise;
        wire t_fall;
        always @(posedge mclk_i or posedge rst_i) begin
          if (rst_i) begin
            tog_q <= 1'b0;
          end else if (ps_pulse & ext_sel) begin
            tog_q <= ~tog_q;
          end
        end
        gtm_sync u_post (
          .mclk_i(mclk_i),
          .rst_i(rst_i),
          .d_i(tog_q),
          .bypass_i(1'b0),
          .lvl_o(),
          .rise_o(t_rise),
          .fall_o(t_fall)
        );
        assign inc_w[gi] = run & (ext_sel ? (t_rise | t_fall) : ps_pulse);
      end else begin : g_direct
        assign inc_w[gi] = ps_pulse;
      end

      assign gfall_w[gi] = gate & on & pin_fall;

      // Paired, C advances on the carry out of B and ignores its own
      assign adv = (gi == 2) ?
        (pair_w ? (inc_w[1] & (cnt_b == `GTM_CNT_MAX)) : inc_w[2]) :
        inc_w[gi];
      assign clr = hit_w[gi] | ((gi == 1) & pair_w & hit_w[2]);

      // Registers; a software write to the count beats an increment
      always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_q <= `GTM_RST_CNT;
          per_q <= `GTM_RST_PER;
          ctl_q <= `GTM_RST_CTL;
          ie_q <= 1'b0;
          if_q <= 1'b0;
          ip_q <= `GTM_RST_IP;
        end else begin
          if (wr_cnt) begin
            cnt_q <= wdata_i;
          end else if (clr) begin
            cnt_q <= `GTM_RST_CNT;
          end else if (adv) begin
            cnt_q <= cnt_q + 16'h0001;
          end
          if (wr_per) begin
            per_q <= wdata_i;
          end
          if (wr_ctl) begin
            ctl_q <= wdata_i & WMASK;
          end
          if (wr_irq) begin
            ie_q <= wdata_i[`GTM_BIT_IE];
            ip_q <= wdata_i[`GTM_BIT_IP_HI:`GTM_BIT_IP_LO];
          end
          // Hardware set wins over a clear in the same cycle
          if (set_w[gi]) begin
            if_q <= 1'b1;
          end else if (wr_irq) begin
            if_q <= wdata_i[`GTM_BIT_IF];
          end
        end
      end

      // Readback; variant A hides the gate bit or sync bit per source
      always @* begin
        rb = 16'h0000;
        if (addr_i[1:0] == `GTM_REG_CNT) begin
          rb = cnt_q;
        end else if (addr_i[1:0] == `GTM_REG_PER) begin
          rb = per_q;
        end else if (addr_i[1:0] == `GTM_REG_CTL) begin
          rb = ctl_q;
          if (is_a & ext_sel) begin
            rb[`GTM_BIT_GATE] = 1'b0;
          end
          if (is_a & ~ext_sel) begin
            rb[`GTM_BIT_SYNC] = 1'b0;
          end
        end else begin
          rb[`GTM_BIT_IE] = ie_q;
          rb[`GTM_BIT_IF] = if_q;
          rb[`GTM_BIT_IP_HI:`GTM_BIT_IP_LO] = ip_q;
        end
      end

      assign cnt_w[gi*CW +: CW] = cnt_q;
      assign per_w[gi*CW +: CW] = per_q;
      assign ctl_w[gi*CW +: CW] = ctl_q;
      assign rb_w[gi*CW +: CW] = rb;
      assign flag_w[gi] = if_q;
      assign ien_w[gi] = ie_q;
      assign irq_prio_o[gi*3 +: 3] = ip_q;
    end
  endgenerate

  // ****************************************************************
  // Read data, interrupt requests and ADC trigger
  // ****************************************************************
  // Read data stand only in the cycle after the strobe; hole reads 0
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
      irq_q <= 3'h0;
      adc_q <= 1'b0;
    end else begin
      if (rd_i && (addr_i[3:2] != 2'h3)) begin
        rdata_q <= rb_w[{addr_i[3:2], 4'h0} +: 16];
      end else begin
        rdata_q <= 16'h0000;
      end
      irq_q <= flag_w & ien_w;
      adc_q <= hit_w[2];
    end
  end

  assign rdata_o = rdata_q;
  assign irq_req_o = irq_q;
  assign adc_trig_o = adc_q;

endmodule

/* gtm_timer_properties.sv */
// Concurrent checks on the timer register port and interrupt outputs
`timescale 1ns/1ps
module gtm_timer_properties (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  // Interrupt outputs
  input wire [2:0] irq_req_o,
  input wire [8:0] irq_prio_o
);
  // ********************
  // Register port checks
  // ********************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Bus steps that the properties are built from
  sequence s_ctl_rd; rd_i && addr_i[1:0] == 2'h2; endsequence
  sequence s_actl_rd; rd_i && addr_i == 4'h2; endsequence
  sequence s_bctl_wr; wr_i && addr_i == 4'h6; endsequence
  sequence s_bctl_rd; rd_i && addr_i == 4'h6; endsequence
  sequence s_airq_wr; wr_i && addr_i == 4'h3; endsequence
  a_read_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (
    rd_i && addr_i[3:2] == 2'h3 |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_unused_bits: assert property (
    s_ctl_rd |=> (rdata_o & 16'h5F81) == 16'h0000)
    else $error("unimplemented control bit reads one");
  a_gate_ext_zero: assert property (
    s_actl_rd |=> !(rdata_o[1] && rdata_o[6]))
    else $error("gate bit reads one with external source");
  a_sync_int_zero: assert property (
    s_actl_rd |=> !(!rdata_o[1] && rdata_o[2]))
    else $error("sync bit reads one with internal source");
  // Readback of the B control word drops only unimplemented bits
  a_ctlb_readback: assert property (
    s_bctl_wr ##1 !wr_i ##1 s_bctl_rd |=>
      rdata_o == ($past(wdata_i, 3) & 16'hA07A))
    else $error("B control readback wrong");
  a_prio_follow: assert property (
    s_airq_wr |-> ##2 irq_prio_o[2:0] == $past(wdata_i[4:2], 2))
    else $error("A priority output wrong");
  a_irq_masked: assert property (
    s_airq_wr and !wdata_i[0] |-> ##2 !irq_req_o[0])
    else $error("A request with enable cleared");
endmodule
bind gtm_timer gtm_timer_properties i_gtm_timer_properties (
  .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_req_o(irq_req_o),
  .irq_prio_o(irq_prio_o));

/* gtm_pin_model.sv */
// External clock and gate pin source for the timer block
`timescale 1ns/1ps
module gtm_pin_model (
  // Clock
  input wire mclk_i,
  // Pin level
  output reg pin_o
);
  // ********************
  // Pulse source
  // ********************
  initial pin_o = 1'b0;
  // Pin rests low between bursts; levels of four clocks or more keep
  // the sync stages' high and low time needs
  task burst(input integer n, input integer h);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge mclk_i);
        pin_o <= 1'b1;
        repeat (h) @(posedge mclk_i);
        pin_o <= 1'b0;
        repeat (h - 1) @(posedge mclk_i);
      end
    end
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the three-timer block
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg idle = 1'b0;
  reg slp = 1'b0;
  reg lpen = 1'b0;
  reg adc_seen = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg [15:0] v;
  reg [15:0] d;
  reg [1:0] t;
  wire [15:0] rdata;
  wire [2:0] irq;
  wire [8:0] prio;
  wire adc;
  wire pin;
  integer miscompares = 0;
  integer n_compared = 0;
  integer i;
  integer r;
  // ********************
  // Harness
  // ********************
  gtm_timer i_gtm_timer (.mclk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .ext_clk_a_i(pin), .ext_clk_b_i(pin), .ext_clk_c_i(pin),
    .lposc_clk_i(pin), .lposc_en_i(lpen), .idle_i(idle), .sleep_i(slp),
    .irq_req_o(irq), .irq_prio_o(prio), .adc_trig_o(adc));
  gtm_pin_model i_gtm_pin_model (.mclk_i(clk), .pin_o(pin));
  initial forever #2.5 clk = ~clk;
  // Latch the one-cycle trigger so it cannot slip past the sequence
  always @(posedge clk) if (adc === 1'b1) adc_seen <= 1'b1;
  task wrr(input [3:0] a, input [15:0] dv);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= dv;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rdr(input [3:0] a, output [15:0] dv);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 dv = rdata;
    end
  endtask
  task chk(input string n, input [15:0] s, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  // Free-running tick phase leaves one count of slack
  function [15:0] inr(input [15:0] x, input [15:0] e);
    inr = {15'h0000, x + 17'h1 >= e && x <= e + 17'h1};
  endfunction
  function [15:0] ctl_exp(input [1:0] tv, input [15:0] dv);
    begin
      ctl_exp = dv & (tv == 0 ? 16'hA076 : tv == 1 ? 16'hA07A : 16'hA072);
      if (tv == 0 && dv[1]) ctl_exp[6] = 1'b0;
      if (tv == 0 && !dv[1]) ctl_exp[2] = 1'b0;
    end
  endfunction
  // Clear count, run with a control word for n clocks, stop, read count
  task run(input [1:0] tv, input [15:0] c, input integer n);
    begin
      wrr({tv, 2'h0}, 16'h0000);
      wrr({tv, 2'h2}, c);
      repeat (n) @(posedge clk);
      wrr({tv, 2'h2}, 16'h0000);
      rdr({tv, 2'h0}, v);
    end
  endtask
  task print_verdict;
    begin
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Whole run is under 10000 clocks; this span is ten times that
  initial begin
    #500000;
    miscompares = miscompares + 1;
    print_verdict;
  end
  // ********************
  // Scenarios
  // ********************
  initial begin
    v = $urandom(89);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 12; i = i + 1) begin
      rdr(i[3:0], v);
      chk("reset", v, i[1:0] == 1 ? 16'hFFFF : 16'h0000);
    end
    // Run bit held low so control writes never start a count
    for (i = 0; i < 12; i = i + 1) begin
      t = i % 3;
      d = i < 3 ? 16'h7FFF : $urandom & 16'h7FFF;
      wrr({t, 2'h2}, d);
      rdr({t, 2'h2}, v);
      chk("ctl", v, ctl_exp(t, d));
      wrr({t, 2'h2}, 16'h0000);
    end
    wrr(4'hE, 16'hFFFF);
    rdr(4'hE, v);
    chk("unmapped", v, 16'h0000);
    for (i = 0; i < 3; i = i + 1) begin
      d = $urandom & 16'h001D;
      wrr({i[1:0], 2'h3}, d);
      repeat (2) @(posedge clk);
      chk("prio", {13'h0000, prio[3*i +: 3]}, {13'h0000, d[4:2]});
      rdr({i[1:0], 2'h3}, v);
      chk("irq ctl", v, d);
    end
    for (i = 0; i < 4; i = i + 1) begin
      r = i == 3 ? 256 : 1 << (3 * i);
      run(2'h0, {10'h200, i[1:0], 4'h0}, 20 * r);
      chk("prescale", inr(v, 16'h0005), 16'h0001);
    end
    d = v;
    repeat (40) @(posedge clk);
    rdr(4'h0, v);
    chk("stopped", v, d);
    idle <= 1'b1;
    run(2'h0, 16'hA000, 40);
    chk("idle stop", v, 16'h0000);
    run(2'h0, 16'h8000, 40);
    chk("idle run", inr(v, 16'h000A), 16'h0001);
    idle <= 1'b0;
    wrr(4'hB, 16'h0001);
    wrr(4'h9, 16'h0005);
    wrr(4'h8, 16'h0000);
    wrr(4'hA, 16'h8000);
    for (i = 0; i < 100 && irq[2] !== 1'b1; i = i + 1) @(posedge clk);
    wrr(4'hA, 16'h0000);
    chk("irq", {15'h0000, irq[2]}, 16'h0001);
    chk("adc", {15'h0000, adc_seen}, 16'h0001);
    rdr(4'hB, v);
    chk("flag", v, 16'h0003);
    rdr(4'h8, v);
    chk("wrap", inr(v, 16'h0000), 16'h0001);
    wrr(4'hB, 16'h0000);
    wrr(4'h9, 16'hFFFF);
    wrr(4'h8, 16'h0000);
    wrr(4'hA, 16'h8002);
    i_gtm_pin_model.burst(7, 4);
    repeat (10) @(posedge clk);
    rdr(4'h8, v);
    chk("ext", v, 16'h0007);
    slp <= 1'b1;
    lpen <= 1'b1;
    wrr(4'h0, 16'h0000);
    wrr(4'h2, 16'h8002);
    i_gtm_pin_model.burst(3, 4);
    repeat (10) @(posedge clk);
    rdr(4'h8, v);
    chk("sleep", v, 16'h0007);
    rdr(4'h0, v);
    chk("async", v, 16'h0003);
    slp <= 1'b0;
    lpen <= 1'b0;
    wrr(4'h2, 16'h0000);
    wrr(4'hA, 16'h0000);
    // Pin counting on B crosses after its divider; A resyncs on demand
    wrr(4'h4, 16'h0000);
    wrr(4'h6, 16'h8002);
    i_gtm_pin_model.burst(5, 4);
    repeat (10) @(posedge clk);
    wrr(4'h6, 16'h0000);
    rdr(4'h4, v);
    chk("ext b", v, 16'h0005);
    wrr(4'h0, 16'h0000);
    wrr(4'h2, 16'h8006);
    i_gtm_pin_model.burst(4, 4);
    repeat (10) @(posedge clk);
    slp <= 1'b1;
    i_gtm_pin_model.burst(2, 4);
    repeat (10) @(posedge clk);
    slp <= 1'b0;
    wrr(4'h2, 16'h0000);
    rdr(4'h0, v);
    chk("sync sleep", v, 16'h0004);
    // C control stays off: the B word alone must drive the pair
    wrr(4'h8, 16'h0000);
    wrr(4'h4, 16'hFFFE);
    wrr(4'h6, 16'h8008);
    repeat (12) @(posedge clk);
    wrr(4'h6, 16'h0008);
    rdr(4'h8, v);
    chk("pair", v, 16'h0001);
    wrr(4'h6, 16'h0000);
    // A 32-bit match flags C and clears both halves; B stays quiet
    wrr(4'h5, 16'h0003);
    wrr(4'h9, 16'h0000);
    wrr(4'h4, 16'h0000);
    wrr(4'h8, 16'h0000);
    wrr(4'hB, 16'h0000);
    wrr(4'h6, 16'h8008);
    repeat (40) @(posedge clk);
    wrr(4'h6, 16'h0008);
    rdr(4'hB, v);
    chk("pair flag", v, 16'h0002);
    rdr(4'h7, v);
    chk("pair b flag", v & 16'h0002, 16'h0000);
    wrr(4'h6, 16'h0000);
    // Gate mode needs the internal source, so the source bit stays low
    wrr(4'h0, 16'h0000);
    wrr(4'h3, 16'h0000);
    wrr(4'h2, 16'h8040);
    i_gtm_pin_model.burst(1, 200);
    wrr(4'h2, 16'h0000);
    rdr(4'h0, v);
    chk("gate", inr(v, 16'h0032), 16'h0001);
    rdr(4'h3, v);
    chk("gate flag", v & 16'h0002, 16'h0002);
    print_verdict;
  end
endmodule
